// >>> adc_ctrl_consts.svh
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_RESULT_LOW     8'h9B
`define IDX_RESULT_HIGH    8'h9C
`define IDX_CTRL_CHANNEL   8'h9D
`define IDX_CTRL_FMT_CLK   8'h9E
`define IDX_TRIG_SELECT    8'h9F
`define IDX_IRQ_STATUS     8'hA0
`define IDX_IRQ_MASK       8'hA1
`define IDX_CONV_STATUS    8'hA2
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define CH_ENABLE_BIT      0
`define CH_START_BIT       1
`define FMT_JUSTIFY_BIT    7
`define FMT_WRITE_MASK     8'hF3
`define TRIG_WRITE_MASK    8'h0F
`define RESULT_RESET       16'h0000
`define FMT_RESET          8'h00
`define CHAN_RESET         8'h00
`define TRIG_RESET         8'h00
`define RESULT_BITS        10
`define CONV_TICKS         12
`define IRQ_DONE_BIT       0
`define IRQ_TRIG_BIT       1
`endif

// >>> adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } conv_state_t;

  typedef enum logic [3:0] {
    TRG_OFF      = 4'h0,
    TRG_PIN      = 4'h1,
    TRG_TMR0     = 4'h2,
    TRG_TMR1     = 4'h3,
    TRG_TMR2     = 4'h4,
    TRG_CAP1     = 4'h5,
    TRG_CAP2     = 4'h6,
    TRG_PWM3     = 4'h7,
    TRG_PWM4     = 4'h8,
    TRG_IOC      = 4'h9,
    TRG_HIGHREAD = 4'hD
  } trig_code_t;

  typedef enum logic [1:0] {
    REF_SUPPLY   = 2'b00,
    REF_RESERVED = 2'b01,
    REF_PIN      = 2'b10,
    REF_FIXED    = 2'b11
  } ref_sel_t;

  typedef struct packed {
    logic timer_zero_wrap;
    logic timer_one_wrap;
    logic timer_two_postscaled;
    logic capcomp_one_output;
    logic capcomp_two_output;
    logic pulse_unit_three_output;
    logic pulse_unit_four_output;
    logic change_flag;
    logic mapped_pin;
  } trig_inputs_t;

  typedef struct packed {
    logic       valid;
    logic       is_port_b;
    logic       is_port_c;
    logic [4:0] line;
  } chan_decode_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// >>> adc_clock_divider.sv
`default_nettype none
`include "adc_ctrl_consts.svh"
module adc_clock_divider (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] clock_select,
  input  wire logic       rc_tick,
  // tick out
  output logic            conv_tick
);
  logic [5:0] count_reg;
  logic [5:0] limit;

  // ----------------------------------------------------------------
  // divide ratio per clock select
  // ----------------------------------------------------------------
  always_comb begin
    case (clock_select)
      3'h0:    limit = 6'h01;
      3'h1:    limit = 6'h07;
      3'h2:    limit = 6'h1F;
      3'h4:    limit = 6'h03;
      3'h5:    limit = 6'h0F;
      3'h6:    limit = 6'h3F;
      default: limit = 6'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 6'h00;
    end else if (!run || count_reg >= limit) begin
      count_reg <= 6'h00;
    end else begin
      count_reg <= count_reg + 6'h01;
    end
  end

  // rc codes 011 and 111 follow the dedicated rc tick
  assign conv_tick = run && ((clock_select[1:0] == 2'b11) ? rc_tick : (count_reg >= limit));
endmodule : adc_clock_divider
`default_nettype wire

// >>> adc_control_registers.sv
`default_nettype none
`include "adc_ctrl_consts.svh"
module adc_control_registers
  import adc_ctrl_pkg::*;
#(
  parameter logic [1:0] PACKAGE_SIZE = 2'd2
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // trigger sources and rc clock
  input  wire adc_ctrl_pkg::trig_inputs_t trig_in,
  input  wire logic                       rc_clock_in,
  // analog front end
  input  wire logic [`RESULT_BITS-1:0]    sample_value,
  output adc_ctrl_pkg::chan_decode_t      channel_route,
  output adc_ctrl_pkg::ref_sel_t          reference_route,
  output logic                            converter_power,
  output logic                            converting,
  // interrupt
  output logic                            irq
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]  result_reg;
  logic [7:0]   chan_reg;
  logic [7:0]   fmt_reg;
  logic [7:0]   trig_reg;
  logic [1:0]   irq_status_reg;
  logic [1:0]   irq_mask_reg;
  conv_state_t  state_reg;
  logic [3:0]   tick_count_reg;
  logic         wr_pending_reg;
  logic         rd_pending_reg;
  logic [7:0]   addr_idx_reg;
  logic [8:0]   trig_sync1_reg;
  logic [8:0]   trig_sync2_reg;
  logic         trig_prev_reg;
  logic [2:0]   rc_sync_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       access;
  logic [7:0] addr_idx;
  logic       wr_chan;
  logic       wr_fmt;
  logic       wr_trig;
  logic       wr_mask;
  logic       wr_result_low;
  logic       wr_result_high;
  logic       rd_strobe;
  logic       rd_high;
  logic       rd_status;
  logic [31:0] rd_word;

  assign access    = hsel && hready && htrans[1];
  assign addr_idx  = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction : hit

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pending_reg <= 1'b0;
      rd_pending_reg <= 1'b0;
      addr_idx_reg   <= 8'h00;
    end else begin
      wr_pending_reg <= access && hwrite;
      rd_pending_reg <= access && !hwrite;
      if (access) begin
        addr_idx_reg <= addr_idx;
      end
    end
  end

  assign wr_chan        = wr_pending_reg && hit(addr_idx_reg, `IDX_CTRL_CHANNEL);
  assign wr_fmt         = wr_pending_reg && hit(addr_idx_reg, `IDX_CTRL_FMT_CLK);
  assign wr_trig        = wr_pending_reg && hit(addr_idx_reg, `IDX_TRIG_SELECT);
  assign wr_mask        = wr_pending_reg && hit(addr_idx_reg, `IDX_IRQ_MASK);
  assign wr_result_low  = wr_pending_reg && hit(addr_idx_reg, `IDX_RESULT_LOW);
  assign wr_result_high = wr_pending_reg && hit(addr_idx_reg, `IDX_RESULT_HIGH);
  assign rd_strobe      = access && !hwrite;
  assign rd_high        = rd_strobe && hit(addr_idx, `IDX_RESULT_HIGH);
  assign rd_status      = rd_strobe && hit(addr_idx, `IDX_IRQ_STATUS);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic enabled;
  logic conv_start;
  logic conv_done;
  assign enabled = chan_reg[`CH_ENABLE_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt_reg  <= `FMT_RESET;
      trig_reg <= `TRIG_RESET;
    end else begin
      if (wr_fmt) begin
        fmt_reg <= hwdata[7:0] & `FMT_WRITE_MASK;
      end
      if (wr_trig) begin
        trig_reg <= hwdata[7:0] & `TRIG_WRITE_MASK;
      end
    end
  end

  // channel and enable bits; start bit owned by the sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_reg[7:0] <= `CHAN_RESET;
    end else begin
      if (wr_chan) begin
        chan_reg[7:2] <= hwdata[7:2];
        chan_reg[0]   <= hwdata[0];
      end
      if (conv_done || !enabled) begin
        chan_reg[`CH_START_BIT] <= 1'b0;
      end
      if (conv_start) begin
        chan_reg[`CH_START_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel and reference routing
  // ----------------------------------------------------------------
  function automatic chan_decode_t decode_channel(input logic [5:0] code, input logic [1:0] pkg);
    chan_decode_t d;
    d = '0;
    case (code)
      6'h00, 6'h01, 6'h02, 6'h04, 6'h05: begin
        d.valid = 1'b1;
        d.line  = code[4:0];
      end
      6'h0D, 6'h0E, 6'h0F: begin
        d.valid     = (pkg == 2'd2);
        d.is_port_b = d.valid;
        d.line      = code[4:0] - 5'h08;
      end
      6'h12, 6'h13, 6'h14, 6'h15: begin
        d.valid     = (pkg != 2'd0);
        d.is_port_c = d.valid;
        d.line      = code[4:0] - 5'h10;
      end
      6'h1B, 6'h1E: begin
        d.valid = 1'b1;
        d.line  = code[4:0];
      end
      default: d = '0;
    endcase
    return d;
  endfunction : decode_channel

  assign channel_route   = decode_channel(chan_reg[7:2], PACKAGE_SIZE);
  assign reference_route = ref_sel_t'(fmt_reg[1:0]);
  assign converter_power = enabled;

  // ----------------------------------------------------------------
  // hardware trigger selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_sync1_reg <= 9'h000;
      trig_sync2_reg <= 9'h000;
      rc_sync_reg    <= 3'h0;
    end else begin
      trig_sync1_reg <= trig_in;
      trig_sync2_reg <= trig_sync1_reg;
      rc_sync_reg    <= {rc_sync_reg[1], rc_sync_reg[0], rc_clock_in};
    end
  end

  trig_inputs_t trig_s;
  logic         trig_level;
  assign trig_s = trig_inputs_t'(trig_sync2_reg);

  always_comb begin
    case (trig_code_t'(trig_reg[3:0]))
      TRG_PIN:  trig_level = trig_s.mapped_pin;
      TRG_TMR0: trig_level = trig_s.timer_zero_wrap;
      TRG_TMR1: trig_level = trig_s.timer_one_wrap;
      TRG_TMR2: trig_level = trig_s.timer_two_postscaled;
      TRG_CAP1: trig_level = trig_s.capcomp_one_output;
      TRG_CAP2: trig_level = trig_s.capcomp_two_output;
      TRG_PWM3: trig_level = trig_s.pulse_unit_three_output;
      TRG_PWM4: trig_level = trig_s.pulse_unit_four_output;
      TRG_IOC:  trig_level = trig_s.change_flag;
      default:  trig_level = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_level;
    end
  end

  logic hw_trigger;
  logic sw_start;
  assign hw_trigger = (trig_level && !trig_prev_reg)
                   || (trig_reg[3:0] == TRG_HIGHREAD && rd_high);
  assign sw_start   = wr_chan && hwdata[`CH_START_BIT] && hwdata[`CH_ENABLE_BIT];
  assign conv_start = enabled && (state_reg == ST_IDLE) && (sw_start || hw_trigger);

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  logic conv_tick;

  adc_clock_divider u_div (
    .clk          (clk),
    .reset_n      (reset_n),
    .run          (state_reg == ST_CONV),
    .clock_select (fmt_reg[6:4]),
    .rc_tick      (rc_sync_reg[1] && !rc_sync_reg[2]),
    .conv_tick    (conv_tick)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= ST_IDLE;
      tick_count_reg <= 4'h0;
    end else if (!enabled) begin
      state_reg      <= ST_IDLE;
      tick_count_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          tick_count_reg <= 4'h0;
          if (conv_start) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_tick) begin
            tick_count_reg <= tick_count_reg + 4'h1;
            if (tick_count_reg == 4'(`CONV_TICKS - 1)) begin
              state_reg <= ST_DONE;
            end
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign conv_done  = (state_reg == ST_DONE);
  assign converting = chan_reg[`CH_START_BIT];

  // ----------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------
  function automatic logic [15:0] justify(input logic [9:0] v, input logic right);
    justify = right ? {6'h00, v} : {v, 6'h00};
  endfunction : justify

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= `RESULT_RESET;
    end else if (conv_done) begin
      result_reg <= justify(sample_value, fmt_reg[`FMT_JUSTIFY_BIT]);
    end else begin
      if (wr_result_low) begin
        result_reg[7:0] <= hwdata[7:0];
      end
      if (wr_result_high) begin
        result_reg[15:8] <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= 2'h0;
      irq_mask_reg   <= 2'h0;
    end else begin
      if (wr_mask) begin
        irq_mask_reg <= hwdata[1:0];
      end
      irq_status_reg <= (rd_status ? 2'h0 : irq_status_reg)
                      | {hw_trigger && conv_start, conv_done};
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    case (addr_idx)
      `IDX_RESULT_LOW:   rd_word = {24'h000000, result_reg[7:0]};
      `IDX_RESULT_HIGH:  rd_word = {24'h000000, result_reg[15:8]};
      `IDX_CTRL_CHANNEL: rd_word = {24'h000000, chan_reg};
      `IDX_CTRL_FMT_CLK: rd_word = {24'h000000, fmt_reg};
      `IDX_TRIG_SELECT:  rd_word = {24'h000000, trig_reg};
      `IDX_IRQ_STATUS:   rd_word = {30'h0000000, irq_status_reg};
      `IDX_IRQ_MASK:     rd_word = {30'h0000000, irq_mask_reg};
      `IDX_CONV_STATUS:  rd_word = {30'h0000000, state_reg};
      default:           rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_strobe) begin
      hrdata <= rd_word;
    end
  end
endmodule : adc_control_registers
`default_nettype wire

// >>> adc_control_registers_monitor.sv
`default_nettype none
`include "adc_ctrl_consts.svh"
module adc_control_registers_monitor
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       reset_n,
  // bus
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  // converter side
  input wire adc_ctrl_pkg::chan_decode_t channel_route,
  input wire adc_ctrl_pkg::ref_sel_t     reference_route,
  input wire logic                       converter_power,
  input wire logic                       converting
);
  // ---------------------------------------------
  // bus phase tracking
  // ---------------------------------------------
  logic       take;
  logic       ph_wr;
  logic       ph_rd;
  logic [7:0] ph_idx;
  logic [3:0] trig_q;
  logic [7:0] run_cnt;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_wr  <= 1'b0;
      ph_rd  <= 1'b0;
      ph_idx <= 8'h00;
    end else begin
      ph_wr  <= take && hwrite;
      ph_rd  <= take && !hwrite;
      if (take) ph_idx <= haddr[9:2];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) trig_q <= 4'h0;
    else if (ph_wr && ph_idx == `IDX_TRIG_SELECT) trig_q <= hwdata[3:0];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_cnt <= 8'h00;
    else if (!converting) run_cnt <= 8'h00;
    else if (run_cnt != 8'hFF) run_cnt <= run_cnt + 8'h01;
  end
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_power_follows_enable: assert property (
    ph_wr && ph_idx == `IDX_CTRL_CHANNEL |=> converter_power == $past(hwdata[`CH_ENABLE_BIT]))
    else $error("power does not follow enable write");
  a_start_needs_enable: assert property (
    $rose(converting) |-> converter_power)
    else $error("conversion started while disabled");
  a_start_holds_busy: assert property (
    $fell(converting) && converter_power |-> run_cnt >= 8'd20)
    else $error("start bit cleared too early");
  a_ref_follows_write: assert property (
    ph_wr && ph_idx == `IDX_CTRL_FMT_CLK |=> reference_route == $past(hwdata[1:0]))
    else $error("reference select mismatch");
  a_fmt_unused_zero: assert property (
    ph_rd && ph_idx == `IDX_CTRL_FMT_CLK |-> hrdata[3:2] == 2'b00)
    else $error("format register unused bits not zero");
  a_trig_unused_zero: assert property (
    ph_rd && ph_idx == `IDX_TRIG_SELECT |-> hrdata[7:4] == 4'h0)
    else $error("trigger register unused bits not zero");
  a_porta_decode: assert property (
    ph_wr && ph_idx == `IDX_CTRL_CHANNEL && hwdata[7:2] inside {6'h00, 6'h01, 6'h02, 6'h04, 6'h05}
    |=> channel_route.valid && channel_route.line == $past(hwdata[6:2])
        && !channel_route.is_port_b && !channel_route.is_port_c)
    else $error("port A channel decode wrong");
  a_reserved_channel: assert property (
    ph_wr && ph_idx == `IDX_CTRL_CHANNEL && hwdata[7:2] == 6'h03 |=> !channel_route.valid)
    else $error("reserved channel decoded as valid");
  a_high_read_starts: assert property (
    take && !hwrite && haddr[9:2] == `IDX_RESULT_HIGH && trig_q == 4'hD && converter_power && !converting
    |-> ##[1:4] converting)
    else $error("high byte read did not start conversion");
  a_read_data_holds: assert property (
    !(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
endmodule : adc_control_registers_monitor

bind adc_control_registers adc_control_registers_monitor u_adc_control_registers_monitor (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .channel_route(channel_route),
  .reference_route(reference_route), .converter_power(converter_power), .converting(converting)
);
`default_nettype wire

// >>> tb_adc_control_registers.sv
`default_nettype none
`include "adc_ctrl_consts.svh"
module tb_adc_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  logic         clk, reset_n, hsel, hwrite, hresp, hreadyout, irq, rc_clock_in, converter_power, converting;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [9:0]   sample_value;
  trig_inputs_t trig_in;
  chan_decode_t channel_route;
  ref_sel_t     reference_route;
  int           n_mismatch, checked, rc_cnt;
  int           divs[8] = '{2, 8, 32, 10, 4, 16, 64, 10};
  // ---------------------------------------------
  // clocks and design
  // ---------------------------------------------
  always #2 clk = ~clk;
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    if (rc_cnt == 4) rc_clock_in <= ~rc_clock_in;
  end
  adc_control_registers u_adc_control_registers (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trig_in(trig_in), .rc_clock_in(rc_clock_in), .sample_value(sample_value),
    .channel_route(channel_route), .reference_route(reference_route),
    .converter_power(converter_power), .converting(converting), .irq(irq)
  );
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wt;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : wt
  task bus_wr(input logic [7:0] idx, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    wt();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wt();
  endtask : bus_wr
  task rd_chk(input string w, input logic [7:0] idx, input logic [7:0] exp);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr  <= {22'h0, idx, 2'b00};
    wt();
    htrans <= 2'b00;
    wt();
    chk(w, {24'h0, exp}, hrdata);
  endtask : rd_chk
  task wait_idle;
    while (converting === 1'b1) @(posedge clk);
  endtask : wait_idle
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_regs;
    rd_chk("result_low", `IDX_RESULT_LOW, 8'h00);
    rd_chk("result_high", `IDX_RESULT_HIGH, 8'h00);
    rd_chk("fmt_reset", `IDX_CTRL_FMT_CLK, 8'h00);
    rd_chk("unmapped", 8'h40, 8'h00);
    bus_wr(`IDX_RESULT_LOW, 8'hA5);
    bus_wr(`IDX_RESULT_HIGH, 8'h3C);
    rd_chk("result_low_rw", `IDX_RESULT_LOW, 8'hA5);
    rd_chk("result_high_rw", `IDX_RESULT_HIGH, 8'h3C);
    bus_wr(`IDX_CTRL_FMT_CLK, 8'hFF);
    rd_chk("fmt_mask", `IDX_CTRL_FMT_CLK, 8'hF3);
    bus_wr(`IDX_TRIG_SELECT, 8'hFF);
    rd_chk("trig_mask", `IDX_TRIG_SELECT, 8'h0F);
    bus_wr(`IDX_TRIG_SELECT, 8'h00);
  endtask : t_regs
  task t_channels;
    logic v, b, c;
    logic [4:0] l;
    for (int k = 0; k < 64; k++) begin
      bus_wr(`IDX_CTRL_CHANNEL, {k[5:0], 2'b00});
      @(posedge clk);
      b = k >= 13 && k <= 15;
      c = k >= 18 && k <= 21;
      v = k <= 2 || k == 4 || k == 5 || k == 27 || k == 30 || b || c;
      l = b ? 5'(k - 8) : c ? 5'(k - 16) : v ? 5'(k) : 5'h00;
      chk("route", 32'({v, b, c, l}), 32'(channel_route));
    end
  endtask : t_channels
  task t_conv;
    logic [7:0] f;
    logic [9:0] v;
    int d;
    for (int c = 0; c < 8; c++) begin
      f = {c[0], c[2:0], 2'b00, c[1:0]};
      v = {c[2:0], 7'h5A};
      sample_value <= v;
      bus_wr(`IDX_IRQ_MASK, {7'h0, c[1]});
      bus_wr(`IDX_CTRL_FMT_CLK, f);
      bus_wr(`IDX_CTRL_CHANNEL, 8'h01);
      @(posedge clk);
      chk("reference", 32'(c[1:0]), 32'(reference_route));
      chk("power_on", 32'h1, 32'(converter_power));
      bus_wr(`IDX_CTRL_CHANNEL, 8'h03);
      rd_chk("start_busy", `IDX_CTRL_CHANNEL, 8'h03);
      d = 4;
      while (converting === 1'b1) begin
        @(posedge clk);
        d++;
      end
      chk("conv_len", 32'h1, 32'(d >= 11 * divs[c] && d <= 13 * divs[c] + 8));
      rd_chk("start_clear", `IDX_CTRL_CHANNEL, 8'h01);
      rd_chk("high", `IDX_RESULT_HIGH, c[0] ? {6'h0, v[9:8]} : v[9:2]);
      rd_chk("low", `IDX_RESULT_LOW, c[0] ? v[7:0] : {v[1:0], 6'h00});
      chk("irq", 32'(c[1]), 32'(irq));
      rd_chk("status", `IDX_IRQ_STATUS, 8'h01);
      @(posedge clk);
      chk("irq_clear", 32'h0, 32'(irq));
    end
  endtask : t_conv
  task t_abort;
    bus_wr(`IDX_CTRL_CHANNEL, 8'h00);
    bus_wr(`IDX_CTRL_CHANNEL, 8'h02);
    @(posedge clk);
    chk("no_start", 32'h0, 32'(converting));
    bus_wr(`IDX_CTRL_CHANNEL, 8'h01);
    bus_wr(`IDX_CTRL_CHANNEL, 8'h03);
    bus_wr(`IDX_CTRL_CHANNEL, 8'h00);
    repeat (2) @(posedge clk);
    chk("abort", 32'h0, 32'({converting, converter_power}));
  endtask : t_abort
  task t_trig;
    logic seen;
    bus_wr(`IDX_CTRL_FMT_CLK, 8'h00);
    bus_wr(`IDX_CTRL_CHANNEL, 8'h01);
    for (int k = 0; k < 10; k++) begin
      bus_wr(`IDX_TRIG_SELECT, 8'(k));
      seen = 1'b0;
      trig_in <= trig_inputs_t'(k == 0 ? 9'h1FF : 9'h001 << (k == 1 ? 0 : 10 - k));
      for (int i = 0; i < 12; i++) begin
        @(posedge clk);
        if (i == 3) trig_in <= '0;
        if (converting === 1'b1) seen = 1'b1;
      end
      chk("trig_start", 32'(k != 0), 32'(seen));
      wait_idle();
    end
    bus_wr(`IDX_TRIG_SELECT, 8'h0D);
    rd_chk("high_read", `IDX_RESULT_HIGH, sample_value[9:2]);
    seen = 1'b0;
    repeat (4) begin
      if (converting === 1'b1) seen = 1'b1;
      @(posedge clk);
    end
    chk("read_start", 32'h1, 32'(seen));
    wait_idle();
    rd_chk("trig_status", `IDX_IRQ_STATUS, 8'h03);
    bus_wr(`IDX_TRIG_SELECT, 8'h00);
  endtask : t_trig
  // ---------------------------------------------
  // verdict and run
  // ---------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    {clk, hsel, hwrite, rc_clock_in, rc_cnt, n_mismatch, checked} = '0;
    {haddr, hwdata, htrans, sample_value} = '0;
    hsize   = 3'b010;
    trig_in = '0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_channels();
    t_conv();
    t_abort();
    t_trig();
    results();
  end
endmodule : tb_adc_control_registers
`default_nettype wire
